// ===== hw/caw_pkg.sv
// Purpose: shared types and constants of the core alu and working register
// Assumes: one ref_clk cycle per phase, four phases per instruction cycle
// Notes: flag struct bit order matches the low three status bits
//
// Overview of operation
// - 8-bit alu: add, subtract, shift, logic
// - arithmetic is two's complement
// - two operands: working reg plus file or literal
// - one operand: working reg or file register
// - working reg 8 bits, never data-addressable
// - flags updated only by instructions affecting them
// - subtract: carry and nibble flag mean no-borrow
// - 14-bit instruction fetched in one cycle
// - fetch overlaps execute; non-branches take one cycle (taken skips and pc writes also flush and take two)
// - any operation on any file register
// - results written to special registers, pc included
// - direct and indirect file addressing supported
// - pc change takes two cycles, prefetch discarded
// - operand read phase_two, result written phase_four
package caw_pkg;

  // data path and instruction widths
  localparam int DATA_W = 8;
  localparam int INSTR_W = 14;
  localparam int TARGET_W = 11;

  // file address that selects indirect access through the pointer
  localparam logic [6:0] ADDR_INDIRECT = 7'h00;
  // file address of the program counter low byte
  localparam logic [6:0] ADDR_PC_LOW = 7'h02;

  // reset values
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [13:0] INSTR_RESET = 14'h0000;

  // phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_ONE = 2'b00,
    PH_TWO = 2'b01,
    PH_THREE = 2'b10,
    PH_FOUR = 2'b11
  } caw_phase_t;

  // alu operations
  typedef enum logic [4:0] {
    OP_ADD = 5'h00,
    OP_SUB = 5'h01,
    OP_AND = 5'h02,
    OP_IOR = 5'h03,
    OP_XOR = 5'h04,
    OP_COM = 5'h05,
    OP_INC = 5'h06,
    OP_DEC = 5'h07,
    OP_RRF = 5'h08,
    OP_RLF = 5'h09,
    OP_SWAP = 5'h0a,
    OP_PASSA = 5'h0b,
    OP_PASSB = 5'h0c,
    OP_CLR = 5'h0d,
    OP_BCLR = 5'h0e,
    OP_BSET = 5'h0f,
    OP_BTST = 5'h10
  } caw_op_t;

  // kind of program counter change requested at phase_four
  typedef enum logic [2:0] {
    BR_GOTO = 3'h0,
    BR_CALL = 3'h1,
    BR_RET = 3'h2,
    BR_RETLW = 3'h3,
    BR_RETFIE = 3'h4,
    BR_PCWRITE = 3'h5,
    BR_SKIP = 3'h6
  } caw_br_t;

  // status flags, bit 0 zero, bit 1 nibble carry, bit 2 carry
  typedef struct packed {
    logic c;
    logic nibble_overflow_out;
    logic z;
  } caw_flags_t;

  // flag update towards the status register
  typedef struct packed {
    caw_flags_t mask;
    caw_flags_t val;
  } caw_flag_upd_t;

  // data memory request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } caw_dmem_req_t;

  // branch request towards the program counter
  typedef struct packed {
    logic req;
    caw_br_t kind;
    logic [10:0] target;
  } caw_branch_t;

  // decoded control of one instruction
  typedef struct packed {
    caw_op_t op;
    logic lit;
    logic rd_f;
    logic wr_f;
    logic wr_w;
    caw_flags_t aff;
    logic skz;
    logic sknz;
    logic br_en;
    caw_br_t br;
  } caw_ctl_t;

endpackage : caw_pkg

// ===== hw/caw_phase.sv
// Purpose: four-phase sequencer of the instruction cycle
// Assumes: ref_clk at 10 MHz, one phase per clock
// Notes: starts at phase one out of reset
`timescale 1ns/1ps
module caw_phase (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // current phase
  output caw_pkg::caw_phase_t phase
);
  import caw_pkg::*;

  caw_phase_t phase_ff; // running phase
  caw_phase_t nxt_phase;

  // wraps from phase four back to phase one
  assign nxt_phase = caw_phase_t'(phase_ff + 2'h1);
  assign phase = phase_ff;

  // phase register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= PH_ONE;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

endmodule : caw_phase

// ===== hw/caw_alu.sv
// Purpose: 8-bit combinational alu with flag values
// Assumes: caller decides which flags are stored
// Notes: subtract forms b minus a as b plus not a plus one
`timescale 1ns/1ps
module caw_alu (
  // operands
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic cin,
  // operation
  input wire caw_pkg::caw_op_t op,
  input wire logic [2:0] bit_sel,
  // results
  output logic [7:0] res,
  output caw_pkg::caw_flags_t flg
);
  import caw_pkg::*;

  wire is_sub; // subtract selects inverted addend and carry-in
  wire [7:0] addend;
  wire [8:0] sum; // full sum with carry out of bit 7
  wire [4:0] nib_sum; // low nibble sum with carry out of bit 3
  wire [7:0] bmask; // one-hot bit mask for bit operations
  wire is_rot;

  assign is_sub = (op == OP_SUB);
  // two's complement subtract: no borrow shows as carry set
  assign addend = is_sub ? ~opa : opa;
  assign sum = {1'h0, opb} + {1'h0, addend} + {8'h00, is_sub};
  assign nib_sum = {1'h0, opb[3:0]} + {1'h0, addend[3:0]}
                 + {4'h0, is_sub};
  assign bmask = 8'h01 << bit_sel;
  assign is_rot = (op == OP_RRF) || (op == OP_RLF);

  // result selection
  always_comb begin
    case (op)
      OP_ADD, OP_SUB: res = sum[7:0];
      OP_AND: res = opa & opb;
      OP_IOR: res = opa | opb;
      OP_XOR: res = opa ^ opb;
      OP_COM: res = ~opb;
      OP_INC: res = opb + 8'h01;
      OP_DEC: res = opb - 8'h01;
      OP_RRF: res = {cin, opb[7:1]};
      OP_RLF: res = {opb[6:0], cin};
      OP_SWAP: res = {opb[3:0], opb[7:4]};
      OP_PASSA: res = opa;
      OP_PASSB: res = opb;
      OP_BCLR: res = opb & ~bmask;
      OP_BSET: res = opb | bmask;
      OP_BTST: res = opb & bmask; // zero when tested bit clear
      default: res = 8'h00; // clear
    endcase
  end

  // flag values; rotates move the shifted-out bit into carry
  assign flg.c = is_rot ? ((op == OP_RRF) ? opb[0] : opb[7]) : sum[8];
  assign flg.nibble_overflow_out = nib_sum[4];
  assign flg.z = (res == 8'h00);

endmodule : caw_alu

// ===== hw/caw_core.sv
// Purpose: working register, operand path and flag update of the core
// Assumes: program counter, stack and file registers live outside
// Notes: one instruction cycle is four ref_clk cycles
`timescale 1ns/1ps
module caw_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // program memory fetch
  input wire logic [13:0] prog_instr,
  output logic fetch_stb,
  // data memory file
  input wire logic [7:0] dmem_rdata,
  output caw_pkg::caw_dmem_req_t dmem_req,
  // status register and pointer
  input wire caw_pkg::caw_flags_t stat_flags,
  input wire logic bank_sel,
  input wire logic [7:0] fsr_val,
  output caw_pkg::caw_flag_upd_t flag_upd,
  // program counter control
  output caw_pkg::caw_branch_t branch,
  // observation
  output caw_pkg::caw_phase_t phase,
  output logic [7:0] w_out
);
  import caw_pkg::*;

  // full instruction decode into control fields
  function automatic caw_ctl_t decode(input logic [13:0] i);
    caw_ctl_t c;
    logic d;
    c = '0;
    c.op = OP_PASSB;
    c.br = BR_SKIP;
    d = i[7];
    case (i[13:12])
      2'b00: begin
        // byte-oriented file ops, destination by d
        c.rd_f = 1'h1;
        c.wr_f = d;
        c.wr_w = ~d;
        case (i[11:8])
          4'h0: begin
            c.rd_f = 1'h0;
            c.wr_w = 1'h0;
            c.op = OP_PASSA; // store working register to file
            if (!d && i[6:0] == 7'h08) begin
              c.br_en = 1'h1;
              c.br = BR_RET;
            end else if (!d && i[6:0] == 7'h09) begin
              c.br_en = 1'h1;
              c.br = BR_RETFIE;
            end
          end
          4'h1: begin
            c.rd_f = 1'h0;
            c.op = OP_CLR; // clear file or working register
            c.aff.z = 1'h1;
          end
          4'h2: begin
            c.op = OP_SUB;
            c.aff = 3'h7;
          end
          4'h3: begin
            c.op = OP_DEC;
            c.aff.z = 1'h1;
          end
          4'h4: begin
            c.op = OP_IOR;
            c.aff.z = 1'h1;
          end
          4'h5: begin
            c.op = OP_AND;
            c.aff.z = 1'h1;
          end
          4'h6: begin
            c.op = OP_XOR;
            c.aff.z = 1'h1;
          end
          4'h7: begin
            c.op = OP_ADD;
            c.aff = 3'h7;
          end
          4'h8: begin
            c.op = OP_PASSB;
            c.aff.z = 1'h1;
          end
          4'h9: begin
            c.op = OP_COM;
            c.aff.z = 1'h1;
          end
          4'ha: begin
            c.op = OP_INC;
            c.aff.z = 1'h1;
          end
          4'hb: begin
            c.op = OP_DEC; // decrement, skip if zero
            c.skz = 1'h1;
          end
          4'hc: begin
            c.op = OP_RRF;
            c.aff.c = 1'h1;
          end
          4'hd: begin
            c.op = OP_RLF;
            c.aff.c = 1'h1;
          end
          4'he: c.op = OP_SWAP;
          default: begin
            c.op = OP_INC; // increment, skip if zero
            c.skz = 1'h1;
          end
        endcase
      end
      2'b01: begin
        // bit-oriented file ops
        c.rd_f = 1'h1;
        case (i[11:10])
          2'b00: begin
            c.op = OP_BCLR;
            c.wr_f = 1'h1;
          end
          2'b01: begin
            c.op = OP_BSET;
            c.wr_f = 1'h1;
          end
          2'b10: begin
            c.op = OP_BTST; // skip when bit clear
            c.skz = 1'h1;
          end
          default: begin
            c.op = OP_BTST; // skip when bit set
            c.sknz = 1'h1;
          end
        endcase
      end
      2'b10: begin
        c.br_en = 1'h1;
        c.br = i[11] ? BR_GOTO : BR_CALL;
      end
      default: begin
        // literal ops, result to working register except for the unused logic code
        c.lit = 1'h1;
        c.wr_w = 1'h1;
        case (i[11:10])
          2'b00: c.op = OP_PASSB;
          2'b01: begin
            c.op = OP_PASSB;
            c.br_en = 1'h1;
            c.br = BR_RETLW;
          end
          2'b10: begin
            c.aff.z = 1'h1;
            case (i[9:8])
              2'b00: c.op = OP_IOR;
              2'b01: c.op = OP_AND;
              2'b10: c.op = OP_XOR;
              default: begin
                c.wr_w = 1'h0; // unused code acts as no operation
                c.aff = 3'h0;
              end
            endcase
          end
          default: begin
            c.op = i[9] ? OP_ADD : OP_SUB;
            c.aff = 3'h7;
          end
        endcase
      end
    endcase
    return c;
  endfunction : decode

  logic [13:0] ir_ff; // instruction register
  logic irv_ff; // instruction register holds a live instruction
  logic [7:0] addr_ff; // resolved file address
  logic [7:0] opnd_ff; // file operand read in phase_two
  logic [7:0] res_ff; // alu result held to phase_four
  caw_flags_t flg_ff; // flag values held to phase_four
  logic [7:0] w_ff; // working register, no file address reaches it
  logic [13:0] nxt_ir;
  logic nxt_irv;
  logic [7:0] nxt_addr;
  logic [7:0] nxt_w;

  caw_ctl_t ctl; // control of the executing instruction
  wire ph1;
  wire ph2;
  wire ph3;
  wire ph4;
  wire [7:0] opb; // second operand, file or literal
  wire [7:0] alu_res;
  caw_flags_t alu_flg;
  wire exec4; // live instruction finishing this cycle
  wire pc_hit; // result lands on the program counter low byte
  wire skip_hit; // skip condition met
  wire flush; // discard the prefetched instruction

  // phase sequencer
  caw_phase u_phase (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .phase(phase)
  );

  // arithmetic and logic unit
  caw_alu u_alu (
    .opa(w_ff),
    .opb(opb),
    .cin(stat_flags.c),
    .op(ctl.op),
    .bit_sel(ir_ff[9:7]),
    .res(alu_res),
    .flg(alu_flg)
  );

  // phase decode
  assign ph1 = (phase == PH_ONE);
  assign ph2 = (phase == PH_TWO);
  assign ph3 = (phase == PH_THREE);
  assign ph4 = (phase == PH_FOUR);

  assign ctl = decode(ir_ff);
  assign opb = ctl.lit ? ir_ff[7:0] : opnd_ff;
  assign exec4 = ph4 && irv_ff;

  // writes to the pc byte change program flow like a branch
  assign pc_hit = ctl.wr_f && (addr_ff[6:0] == ADDR_PC_LOW);
  assign skip_hit = (ctl.skz && flg_ff.z) || (ctl.sknz && !flg_ff.z);
  assign flush = exec4 && (ctl.br_en || pc_hit || skip_hit);

  // indirect access when the file field names the indirect slot;
  // direct access adds the bank select as the top address bit
  assign nxt_addr = (ir_ff[6:0] == ADDR_INDIRECT) ? fsr_val
                  : {bank_sel, ir_ff[6:0]};

  // fetch lands at phase_four; a flushed slot becomes a bubble
  assign nxt_ir = ph4 ? prog_instr : ir_ff;
  assign nxt_irv = ph4 ? !flush : irv_ff;

  // working register takes the result only at phase_four
  assign nxt_w = (exec4 && ctl.wr_w) ? res_ff : w_ff;

  // fetch strobe, one ref_clk cycle per instruction cycle
  assign fetch_stb = ph4;

  // file access: read in phase_two, write in phase_four
  assign dmem_req.addr = addr_ff;
  assign dmem_req.wdata = res_ff;
  assign dmem_req.rd = ph2 && irv_ff && ctl.rd_f;
  assign dmem_req.wr = exec4 && ctl.wr_f;

  // only flags the instruction defines are offered for update
  assign flag_upd.mask = exec4 ? ctl.aff : 3'h0;
  assign flag_upd.val = flg_ff;

  // branch request; skip and pc writes flush like branches
  assign branch.req = flush;
  assign branch.kind = ctl.br_en ? ctl.br
                     : (pc_hit ? BR_PCWRITE : BR_SKIP);
  assign branch.target = ir_ff[10:0];

  assign w_out = w_ff;

  // instruction register and its valid bit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ir_ff <= INSTR_RESET;
      irv_ff <= 1'h0; // first cycle after reset executes nothing
    end else begin
      ir_ff <= nxt_ir;
      irv_ff <= nxt_irv;
    end
  end

  // address resolve in phase_one; pointer sampled here, so a
  // pointer write by the previous instruction is already seen
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_ff <= 8'h00;
    end else if (ph1) begin
      addr_ff <= nxt_addr;
    end
  end

  // operand capture at the end of phase_two
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      opnd_ff <= 8'h00;
    end else if (ph2) begin
      opnd_ff <= dmem_rdata;
    end
  end

  // alu result and flags held in phase_three
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      res_ff <= 8'h00;
      flg_ff <= 3'h0;
    end else if (ph3) begin
      res_ff <= alu_res;
      flg_ff <= alu_flg;
    end
  end

  // working register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      w_ff <= W_RESET;
    end else begin
      w_ff <= nxt_w;
    end
  end

endmodule : caw_core

// ===== bench/caw_core_assertions.sv
// Purpose: port timing checks of the core alu and working register
// Assumes: one phase per ref_clk, four phases per instruction cycle
// Notes: bound onto caw_core after the module
`timescale 1ns/1ps
module caw_core_chk
  import caw_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // observed outputs
  input wire logic fetch_stb,
  input wire caw_pkg::caw_dmem_req_t dmem_req,
  input wire caw_pkg::caw_flag_upd_t flag_upd,
  input wire caw_pkg::caw_branch_t branch,
  input wire caw_pkg::caw_phase_t phase,
  input wire logic [7:0] w_out
);
  import caw_pkg::*;
  // single domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  fetch_strobe_a: assert property (
    fetch_stb == (phase == PH_FOUR))
    else $error("fetch strobe outside phase four");
  // every phase steps to the next, four wrapping back to one
  phase_step_a: assert property (
    1'b1 |=> 2'(phase) == 2'($past(phase) + 2'd1))
    else $error("phase skipped");
  read_phase_a: assert property (
    dmem_req.rd |-> phase == PH_TWO)
    else $error("file read outside phase two");
  write_phase_a: assert property (
    dmem_req.wr |-> fetch_stb)
    else $error("file write outside phase four");
  mask_phase_a: assert property (
    flag_upd.mask != 3'b000 |-> fetch_stb)
    else $error("flag load outside phase four");
  nibble_mask_a: assert property (
    flag_upd.mask.nibble_overflow_out |-> flag_upd.mask.c && flag_upd.mask.z)
    else $error("nibble flag alone");
  // the discarded prefetch must leave no trace for a whole cycle
  branch_bubble_a: assert property (
    branch.req |=> (!dmem_req.rd && !dmem_req.wr && !branch.req &&
    flag_upd.mask == 3'b000) [*4])
    else $error("prefetch after branch not discarded");
  addr_hold_a: assert property (
    phase == PH_TWO |=> $stable(dmem_req.addr) [*3])
    else $error("file address moved");
  w_update_a: assert property (
    $changed(w_out) |-> $past(phase) == PH_FOUR)
    else $error("working register off cycle end");
  // main scenarios reached
  cover property (dmem_req.wr);
  cover property (branch.req && branch.kind == BR_SKIP);
  cover property (flag_upd.mask == 3'b111);
endmodule : caw_core_chk

bind caw_core caw_core_chk i_chk (.ref_clk(ref_clk), .nrst(nrst),
  .fetch_stb(fetch_stb), .dmem_req(dmem_req), .flag_upd(flag_upd),
  .branch(branch), .phase(phase), .w_out(w_out));

// ===== bench/caw_file_model.sv
// Purpose: data file and status flag holder facing the core
// Assumes: writes and flag loads land on the edge ending phase four
// Notes: a released read bus shows the inverse of the last byte read
`timescale 1ns/1ps
module caw_file_model
  import caw_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // requests from the core
  input wire caw_pkg::caw_dmem_req_t dmem_req,
  input wire caw_pkg::caw_flag_upd_t flag_upd,
  // answers to the core
  output logic [7:0] dmem_rdata,
  output caw_pkg::caw_flags_t stat_flags
);
  import caw_pkg::*;
  logic [7:0] mem_ff [256]; // both banks, bench may preload
  logic [7:0] last_ff; // last byte handed out
  caw_flags_t stat_ff; // carry, nibble, zero
  // pattern fill so no read returns unknowns
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem_ff[i] = 8'(i * 29) ^ 8'h5a;
    end
  end
  // file write and read capture
  always @(posedge ref_clk) begin
    if (dmem_req.wr) begin
      mem_ff[dmem_req.addr] <= dmem_req.wdata;
    end
    if (dmem_req.rd) begin
      last_ff <= mem_ff[dmem_req.addr];
    end
  end
  // only masked flags load, others keep their value
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stat_ff <= 3'b000;
    end else begin
      stat_ff <= caw_flags_t'((stat_ff & ~flag_upd.mask) |
        (flag_upd.val & flag_upd.mask));
    end
  end
  assign dmem_rdata = dmem_req.rd ? mem_ff[dmem_req.addr] : ~last_ff;
  assign stat_flags = stat_ff;
endmodule : caw_file_model

// ===== bench/caw_core_bench.sv
// Purpose: self-checking bench of the core alu and working register
// Assumes: word 14'h0000 is a no-op
// Notes: each instruction is followed by one pipeline slot word
`timescale 1ns/1ps
module caw_core_bench;
  import caw_pkg::*;
  // design inputs
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [13:0] prog_instr = 14'h0000;
  logic bank_sel = 1'b0;
  logic [7:0] fsr_val = 8'h20;
  // design outputs and model answers
  logic [7:0] dmem_rdata;
  logic [7:0] w_out;
  logic fetch_stb;
  caw_dmem_req_t dmem_req;
  caw_flags_t stat_flags;
  caw_flag_upd_t flag_upd;
  caw_branch_t branch;
  caw_phase_t phase;
  // bookkeeping
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 60526;
  logic [5:0] ops [24] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
    6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h30, 6'h38, 6'h39,
    6'h3a, 6'h3c, 6'h3e, 6'h10, 6'h15, 6'h1a, 6'h1f};

  caw_core i_dut (.ref_clk(ref_clk), .nrst(nrst), .prog_instr(prog_instr),
    .fetch_stb(fetch_stb), .dmem_rdata(dmem_rdata), .dmem_req(dmem_req),
    .stat_flags(stat_flags), .bank_sel(bank_sel), .fsr_val(fsr_val),
    .flag_upd(flag_upd), .branch(branch), .phase(phase), .w_out(w_out));
  caw_file_model i_file (.ref_clk(ref_clk), .nrst(nrst),
    .dmem_req(dmem_req), .flag_upd(flag_upd), .dmem_rdata(dmem_rdata),
    .stat_flags(stat_flags));

  // 100 ns clock
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input string nm, input logic [15:0] got,
      input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic results();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  // expected {mask, flags, result}; unknown words keep w and flags
  function automatic logic [13:0] calc(input logic [13:0] ins,
      input logic [7:0] w, input logic [7:0] fv, input logic c);
    logic [7:0] a;
    logic [7:0] r;
    logic [8:0] s;
    logic [4:0] h;
    logic [2:0] m;
    logic cc;
    logic [7:0] bm;
    a = (ins[13:12] == 2'b11) ? ins[7:0] : fv;
    r = w;
    m = 3'b001;
    cc = 1'b0;
    bm = 8'h01 << ins[9:7];
    s = {1'b0, w} + {1'b0, a};
    h = {1'b0, w[3:0]} + {1'b0, a[3:0]};
    casez (ins[13:8])
      6'h07, 6'b11_111?: begin r = s[7:0]; m = 3'b111; end
      6'h02, 6'b11_110?: begin
        s = {1'b0, a} + {1'b0, ~w} + 9'h001;
        h = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
        r = s[7:0];
        m = 3'b111;
      end
      6'h05, 6'h39: r = a & w;
      6'h04, 6'h38: r = a | w;
      6'h06, 6'h3a: r = a ^ w;
      6'h09: r = ~a;
      6'h0a: r = a + 8'h01;
      6'h03: r = a - 8'h01;
      6'h08: r = a;
      6'h0b: begin r = a - 8'h01; m = 3'b000; end
      6'h0f: begin r = a + 8'h01; m = 3'b000; end
      6'h0c: begin r = {c, a[7:1]}; cc = a[0]; m = 3'b100; end
      6'h0d: begin r = {a[6:0], c}; cc = a[7]; m = 3'b100; end
      6'h0e: begin r = {a[3:0], a[7:4]}; m = 3'b000; end
      6'b11_00??: begin r = a; m = 3'b000; end
      6'b01_00??: begin r = a & ~bm; m = 3'b000; end
      6'b01_01??: begin r = a | bm; m = 3'b000; end
      6'b01_1???: begin r = a & bm; m = 3'b000; end
      default: m = 3'b000;
    endcase
    return {m, m[1] ? s[8] : cc, h[4], r == 8'h00, r};
  endfunction : calc

  task automatic to_fetch();
    do @(negedge ref_clk); while (phase !== PH_FOUR);
  endtask : to_fetch

  // feed one word, then the slot word, and judge the first
  task automatic exec(input logic [13:0] ins, input logic [13:0] fol);
    logic [7:0] a;
    logic [7:0] w0;
    logic [13:0] e;
    logic [2:0] bk;
    logic [2:0] fm;
    logic wf;
    logic g;
    logic sk;
    logic brq;
    logic dw;
    to_fetch();
    prog_instr = ins;
    bank_sel = 1'($random(seed));
    fsr_val = {1'($random(seed)), 2'b01, 5'($random(seed))};
    w0 = w_out;
    a = (ins[6:0] == 7'h00) ? fsr_val : {bank_sel, ins[6:0]};
    e = calc(ins, w0, i_file.mem_ff[a], i_file.stat_ff.c);
    fm = e[13:11];
    // byte ops write the file when d is set, bit clear and set always do
    wf = ((ins[13:12] == 2'b00) && ins[7]) || (ins[13:11] == 3'b010);
    g = ins[13:12] == 2'b10;
    // count skips on zero; bit tests skip on clear or on set
    sk = ((ins[13:8] == 6'h0b || ins[13:8] == 6'h0f) && e[7:0] == 8'h00)
      || ((ins[13:11] == 3'b011) && ((e[7:0] == 8'h00) != ins[10]));
    bk = g ? (ins[11] ? BR_GOTO : BR_CALL) : sk ? BR_SKIP : BR_PCWRITE;
    brq = g || sk || (wf && a[6:0] == ADDR_PC_LOW[6:0]);
    dw = ins[13:12] == 2'b11 || (ins[13:12] == 2'b00 && !ins[7]);
    to_fetch();
    prog_instr = fol;
    check("fetch", 16'(fetch_stb), 16'h0001);
    check("write", 16'(dmem_req.wr), 16'(wf));
    if (wf) begin
      check("wdata", 16'(dmem_req.wdata), 16'(e[7:0]));
      check("addr", 16'(dmem_req.addr), 16'(a));
    end
    check("mask", 16'(flag_upd.mask), 16'(fm));
    check("flags", 16'(flag_upd.val & fm), 16'(e[10:8] & fm));
    check("branch", 16'(branch.req), 16'(brq));
    if (brq) check("kind", 16'(branch.kind), 16'(bk));
    if (g) check("target", 16'(branch.target), 16'(ins[10:0]));
    @(negedge ref_clk);
    check("w", 16'(w_out), dw ? 16'(e[7:0]) : 16'(w0));
  endtask : exec

  // cycle ceiling
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      results();
    end
  end

  initial begin
    logic [31:0] r;
    logic [5:0] op;
    logic [13:0] ins;
    repeat (2) @(negedge ref_clk);
    check("w reset", 16'(w_out), 16'(W_RESET));
    check("phase reset", 16'(phase), 16'(PH_ONE));
    nrst = 1'b1;
    // branch, call, pc write and taken skips, each with a slot to discard
    exec({3'b101, 11'h5a3}, {6'h30, ~w_out});
    exec({3'b100, 11'h2c5}, {6'h30, ~w_out});
    exec({6'h07, 1'b1, ADDR_PC_LOW[6:0]}, {6'h30, ~w_out});
    i_file.mem_ff[8'h25] = 8'h01;
    i_file.mem_ff[8'ha5] = 8'h01;
    exec({6'h0b, 1'b1, 7'h25}, {6'h30, ~w_out});
    i_file.mem_ff[8'h26] = 8'hff;
    i_file.mem_ff[8'ha6] = 8'hff;
    exec({6'h0f, 1'b0, 7'h26}, {6'h30, ~w_out});
    // borrow and carry boundaries
    exec({6'h30, 8'h01}, 14'h0000);
    exec({6'h3c, 8'h00}, 14'h0000);
    exec({6'h30, 8'h0f}, 14'h0000);
    exec({6'h3e, 8'hf1}, 14'h0000);
    // random traffic over byte and bit operations, banks and indirection
    repeat (80) begin
      r = $random(seed);
      op = ops[r[31:27] % 24];
      ins = (op[5:4] == 2'b11) ? {op, r[7:0]} :
        {op, r[8], (r[2:0] == 3'b000) ? 7'h00 : {2'b01, r[7:3]}};
      exec(ins, 14'h0000);
    end
    results();
  end
endmodule : caw_core_bench
